// *** rtl/stt_pkg.sv ***
// Purpose: Constants, field layout and state types of the 16-bit standard timer
// Assumes: 40 MHz system clock; high-speed clock equal to the system clock
// Notes: Registers are 8 bits wide in the low lane of 32-bit Avalon words
//
// Functional notes
// - 16-bit up counter on selected clock
// - P matches upper byte, A all bits
// - Software clears counter only via run rise
// - Selected match clears, raises flag; clear on A: overflow wraps, no flag
// - Hold bit freezes counter, resumes from value
// - Clock select picks internal divider or pin edge
// - Run bit enables; rising run clears counter
// - Run rise restores initial pin level
// - Mode field picks compare, capture, PWM, timer
// - Compare A match: none, low, high, toggle
// - PWM field: inactive, active, PWM, single pulse
// - Capture edge: rise, fall, both, off
// - Requested level equal initial gives no change
// - Initial level bit: start level or polarity
// - Invert bit flips pin, not capture or timer mode
// - Swap bit exchanges period and duty comparators
// - Clear select: A match, else P/overflow
// - Clear select ignored in PWM and capture
// - Counter read-only bytes, compare registers writable
// - Timer mode leaves pin undriven, field unused
// - P zero gives 65536, else N times 256
// - Clear on A: no P flag ever
// - A zero: overflow at FFFF, no A flag

package stt_pkg;

  // ---------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_CMPP = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int C0_HOLD = 7;
  localparam int C0_CLK_HI = 6;
  localparam int C0_CLK_LO = 4;
  localparam int C0_RUN = 3;
  localparam logic [7:0] C0_MASK = 8'hf8;
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_PF_HI = 5;
  localparam int C1_PF_LO = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_DPX = 1;
  localparam int C1_CCL = 0;
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HI_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HI_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A = 3'h4;
  localparam logic [2:0] CLK_SUB_B = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_LOW = 2'h1;
  localparam logic [1:0] PF_HIGH = 2'h2;
  localparam logic [1:0] PF_TOGGLE = 2'h3;
  localparam logic [1:0] PF_INACTIVE = 2'h0;
  localparam logic [1:0] PF_ACTIVE = 2'h1;
  localparam logic [1:0] PF_PWM = 2'h2;
  localparam logic [1:0] PF_PULSE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAP_OFF = 2'h3;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_CAPTURE,
    MODE_PWM,
    MODE_TIMER
  } stt_mode_t;

  // ---------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [15:0] CMPA_RST = 16'h0000;
  localparam logic [7:0] CMPP_RST = 8'h00;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int SUB_CLK_HZ = 32768;
  localparam int SUB_DIV = SYS_CLK_HZ / SUB_CLK_HZ;
  localparam logic [10:0] SUB_DIV_M1 = 11'(SUB_DIV - 1);
  localparam logic [1:0] PRE4_END = 2'h3;
  localparam logic [3:0] PRE16_END = 4'hf;
  localparam logic [5:0] PRE64_END = 6'h3f;
  localparam logic [16:0] P_ZERO_SPAN = 17'h10000;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [7:0] cmpp;
    logic flag_a;
    logic flag_p;
    logic pin_level;
    logic pin_out;
    logic pin_oe;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic [2:0] cap_sync;
    logic cap_lvl;
    logic [5:0] pre;
    logic [10:0] sub_cnt;
    logic waitrequest;
    logic [31:0] readdata;
  } stt_state_t;

  localparam stt_state_t ST_RESET = '{
    ctrl0: CTRL0_RST,
    ctrl1: CTRL1_RST,
    cmpa: CMPA_RST,
    cmpp: CMPP_RST,
    waitrequest: 1'b1,
    default: '0
  };

endpackage

// *** rtl/stt_timer.sv ***
// Purpose: 16-bit multi-mode timer with two comparators behind an Avalon-MM slave
// Assumes: Single 40 MHz clock; pins are asynchronous and resynchronised here
// Notes: Each access takes two cycles; waitrequest drops for exactly one cycle
`timescale 1ns/1ps

module stt_timer (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [2:0] avs_address, // Word index
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data, low byte used
  input wire logic [3:0] avs_byteenable, // Lane 0 gates writes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic external_count_clock_pin, // External count clock
  input wire logic capture_input_pin, // Capture trigger
  output logic timer_output_pin, // Timer output level
  output logic timer_output_oe, // High while driving the pin
  output logic compare_a_flag, // Comparator A event
  output logic compare_p_flag // Comparator P event
);

  stt_pkg::stt_state_t st;
  stt_pkg::stt_state_t next_st;

  stt_pkg::stt_mode_t mode;
  logic [1:0] pf;
  logic [2:0] clk_sel;
  logic run;
  logic hold;
  logic oc;
  logic tick;
  logic counting;
  logic ext_new;
  logic ext_rise;
  logic ext_fall;
  logic cap_new;
  logic cap_rise;
  logic cap_fall;
  logic cap_evt;
  logic sub_tick;
  logic [16:0] nxt17;
  logic [16:0] p_target;
  logic [16:0] a_target;
  logic [16:0] duty17;
  logic a_hit;
  logic p_hit;
  logic per_hit;
  logic pwm_on;
  logic set_a;
  logic set_p;
  logic clr_a;
  logic clr_p;
  logic taken;
  logic wr;
  logic run_rise_wr;
  logic [7:0] rd_byte;

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    mode = stt_pkg::stt_mode_t'(st.ctrl1[stt_pkg::C1_MODE_HI:stt_pkg::C1_MODE_LO]);
    pf = st.ctrl1[stt_pkg::C1_PF_HI:stt_pkg::C1_PF_LO];
    clk_sel = st.ctrl0[stt_pkg::C0_CLK_HI:stt_pkg::C0_CLK_LO];
    run = st.ctrl0[stt_pkg::C0_RUN];
    hold = st.ctrl0[stt_pkg::C0_HOLD];
    oc = st.ctrl1[stt_pkg::C1_OC];
    set_a = 1'b0;
    set_p = 1'b0;
    cap_evt = 1'b0;
    per_hit = 1'b0;
    rd_byte = 8'h00;

    // Three-stage pin sync; a level counts once stages two and three agree
    next_st.ext_sync = {st.ext_sync[1:0], external_count_clock_pin};
    ext_new = (st.ext_sync[1] == st.ext_sync[2]) ? st.ext_sync[2] : st.ext_lvl;
    ext_rise = ext_new & ~st.ext_lvl;
    ext_fall = ~ext_new & st.ext_lvl;
    next_st.ext_lvl = ext_new;
    next_st.cap_sync = {st.cap_sync[1:0], capture_input_pin};
    cap_new = (st.cap_sync[1] == st.cap_sync[2]) ? st.cap_sync[2] : st.cap_lvl;
    cap_rise = cap_new & ~st.cap_lvl;
    cap_fall = ~cap_new & st.cap_lvl;
    next_st.cap_lvl = cap_new;

    // Free-running prescalers; high-speed clock taken as the system clock
    next_st.pre = st.pre + 6'h01;
    sub_tick = (st.sub_cnt == stt_pkg::SUB_DIV_M1);
    next_st.sub_cnt = sub_tick ? 11'h000 : st.sub_cnt + 11'h001;

    case (clk_sel)
      stt_pkg::CLK_SYS_DIV4: tick = (st.pre[1:0] == stt_pkg::PRE4_END);
      stt_pkg::CLK_SYS: tick = 1'b1;
      stt_pkg::CLK_HI_DIV16: tick = (st.pre[3:0] == stt_pkg::PRE16_END);
      stt_pkg::CLK_HI_DIV64: tick = (st.pre == stt_pkg::PRE64_END);
      stt_pkg::CLK_SUB_A: tick = sub_tick;
      stt_pkg::CLK_SUB_B: tick = sub_tick;
      stt_pkg::CLK_EXT_RISE: tick = ext_rise;
      stt_pkg::CLK_EXT_FALL: tick = ext_fall;
      default: tick = 1'b0;
    endcase

    // Hold and stop both freeze the count without losing it
    counting = run & ~hold & tick;
    nxt17 = {1'b0, st.cnt} + 17'h00001;
    if (counting) begin
      next_st.cnt = nxt17[15:0];
    end

    // P looks only at the top byte, so its span is a multiple of 256
    p_target = (st.cmpp == 8'h00) ? stt_pkg::P_ZERO_SPAN : {1'b0, st.cmpp, 8'h00};
    a_target = {1'b0, st.cmpa};
    a_hit = counting & (st.cmpa != 16'h0000) & (nxt17 == a_target);
    p_hit = counting & (nxt17 == p_target);
    duty17 = st.ctrl1[stt_pkg::C1_DPX] ? p_target : a_target;
    pwm_on = ({1'b0, st.cnt} < duty17);

    case (mode)
      stt_pkg::MODE_COMPARE, stt_pkg::MODE_TIMER: begin
        if (st.ctrl1[stt_pkg::C1_CCL]) begin
          // Clear on A; P flag suppressed here, overflow wraps on its own
          set_a = a_hit;
          if (a_hit) begin
            next_st.cnt = 16'h0000;
          end
        end else begin
          set_a = a_hit;
          set_p = p_hit;
          if (p_hit) begin
            next_st.cnt = 16'h0000;
          end
        end
        if (mode == stt_pkg::MODE_COMPARE && a_hit) begin
          // Driving to the current level is naturally a no-op
          case (pf)
            stt_pkg::PF_NONE: next_st.pin_level = st.pin_level;
            stt_pkg::PF_LOW: next_st.pin_level = 1'b0;
            stt_pkg::PF_HIGH: next_st.pin_level = 1'b1;
            stt_pkg::PF_TOGGLE: next_st.pin_level = ~st.pin_level;
            default: next_st.pin_level = st.pin_level;
          endcase
        end
      end
      stt_pkg::MODE_CAPTURE: begin
        // Clear select has no say here; P always sets the period
        set_p = p_hit;
        if (p_hit) begin
          next_st.cnt = 16'h0000;
        end
        case (pf)
          stt_pkg::CAP_RISE: cap_evt = run & cap_rise;
          stt_pkg::CAP_FALL: cap_evt = run & cap_fall;
          stt_pkg::CAP_BOTH: cap_evt = run & (cap_rise | cap_fall);
          stt_pkg::CAP_OFF: cap_evt = 1'b0;
          default: cap_evt = 1'b0;
        endcase
        if (cap_evt) begin
          next_st.cmpa = st.cnt;
          set_a = 1'b1;
        end
      end
      stt_pkg::MODE_PWM: begin
        per_hit = st.ctrl1[stt_pkg::C1_DPX] ? a_hit : p_hit;
        set_a = a_hit;
        set_p = p_hit;
        if (per_hit) begin
          next_st.cnt = 16'h0000;
        end
        // Initial level bit acts as the active level in this mode
        case (pf)
          stt_pkg::PF_INACTIVE: next_st.pin_level = ~oc;
          stt_pkg::PF_ACTIVE: next_st.pin_level = oc;
          stt_pkg::PF_PWM: next_st.pin_level = pwm_on ? oc : ~oc;
          stt_pkg::PF_PULSE: begin
            if (a_hit) begin
              // Pulse ends at A; the timer switches itself off
              next_st.pin_level = ~oc;
              next_st.ctrl0[stt_pkg::C0_RUN] = 1'b0;
            end
          end
          default: next_st.pin_level = st.pin_level;
        endcase
      end
      default: next_st = st;
    endcase

    // Bus: request taken at the edge where waitrequest is seen low
    taken = (avs_read | avs_write) & ~st.waitrequest;
    wr = taken & avs_write & avs_byteenable[0];
    clr_a = wr & (avs_address == stt_pkg::ADDR_FLAGS) & avs_writedata[stt_pkg::FLAG_A];
    clr_p = wr & (avs_address == stt_pkg::ADDR_FLAGS) & avs_writedata[stt_pkg::FLAG_P];
    run_rise_wr = wr & (avs_address == stt_pkg::ADDR_CTRL0) &
                  avs_writedata[stt_pkg::C0_RUN] & ~run;

    // Set wins over a clear in the same cycle
    next_st.flag_a = (st.flag_a & ~clr_a) | set_a;
    next_st.flag_p = (st.flag_p & ~clr_p) | set_p;

    if (wr) begin
      case (avs_address)
        stt_pkg::ADDR_CTRL0: begin
          next_st.ctrl0 = avs_writedata[7:0] & stt_pkg::C0_MASK;
          if (run_rise_wr) begin
            next_st.cnt = 16'h0000;
            next_st.pin_level = oc;
          end
        end
        stt_pkg::ADDR_CTRL1: next_st.ctrl1 = avs_writedata[7:0];
        stt_pkg::ADDR_CMPA_LO: next_st.cmpa[7:0] = avs_writedata[7:0];
        stt_pkg::ADDR_CMPA_HI: next_st.cmpa[15:8] = avs_writedata[7:0];
        stt_pkg::ADDR_CMPP: next_st.cmpp = avs_writedata[7:0];
        default: next_st.cmpp = next_st.cmpp;
      endcase
    end

    case (avs_address)
      stt_pkg::ADDR_CTRL0: rd_byte = st.ctrl0;
      stt_pkg::ADDR_CTRL1: rd_byte = st.ctrl1;
      stt_pkg::ADDR_CNT_LO: rd_byte = st.cnt[7:0];
      stt_pkg::ADDR_CNT_HI: rd_byte = st.cnt[15:8];
      stt_pkg::ADDR_CMPA_LO: rd_byte = st.cmpa[7:0];
      stt_pkg::ADDR_CMPA_HI: rd_byte = st.cmpa[15:8];
      stt_pkg::ADDR_CMPP: rd_byte = st.cmpp;
      stt_pkg::ADDR_FLAGS: rd_byte = {6'h00, st.flag_p, st.flag_a};
      default: rd_byte = 8'h00;
    endcase

    if ((avs_read | avs_write) & st.waitrequest) begin
      next_st.waitrequest = 1'b0;
      next_st.readdata = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      next_st.waitrequest = 1'b1;
    end

    // Pin released in capture and timer modes
    next_st.pin_oe = (mode == stt_pkg::MODE_COMPARE) | (mode == stt_pkg::MODE_PWM);
    next_st.pin_out = next_st.pin_oe &
                      (next_st.pin_level ^ st.ctrl1[stt_pkg::C1_POL]);
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= stt_pkg::ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign timer_output_pin = st.pin_out;
  assign timer_output_oe = st.pin_oe;
  assign compare_a_flag = st.flag_a;
  assign compare_p_flag = st.flag_p;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  chk_run_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    run_rise_wr |=> (st.cnt == 16'h0000) && st.ctrl0[stt_pkg::C0_RUN])
    else $error("counter not cleared on run rise");

  chk_cnt_steps: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st.cnt != $past(st.cnt)) |->
      (st.cnt == 16'h0000) || (st.cnt == 16'($past(st.cnt) + 16'h0001)))
    else $error("counter moved other than step or clear");

  chk_hold_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hold && !run_rise_wr) |=> $stable(st.cnt))
    else $error("counter moved while held");

  chk_stop_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!run && !run_rise_wr) |=> $stable(st.cnt))
    else $error("counter moved while stopped");

  chk_no_p_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(st.flag_p) |->
      !($past(st.ctrl1[stt_pkg::C1_CCL]) && ($past(mode) != stt_pkg::MODE_PWM) &&
        ($past(mode) != stt_pkg::MODE_CAPTURE)))
    else $error("P flag raised while clearing on A");

  chk_p_upper: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(st.flag_p) |-> ($past(st.cnt[7:0]) == 8'hff) && (st.cnt == 16'h0000 ||
      $past(mode) == stt_pkg::MODE_PWM))
    else $error("P match off a 256 boundary");

  chk_a_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(st.flag_a) && $past(mode) != stt_pkg::MODE_CAPTURE) |-> ($past(st.cmpa) != 16'h0))
    else $error("A flag with compare A zero");

  chk_pin_none: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == stt_pkg::MODE_COMPARE && pf == stt_pkg::PF_NONE && !wr) |=> $stable(st.pin_level))
    else $error("pin changed with no-change field");

  chk_pin_init: assert property (@(posedge sys_clk) disable iff (!resetn)
    (run_rise_wr && mode == stt_pkg::MODE_COMPARE) |=>
      (st.pin_out == ($past(oc) ^ $past(st.ctrl1[stt_pkg::C1_POL]))))
    else $error("pin not at initial level after run rise");

  chk_timer_undrv: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == stt_pkg::MODE_TIMER) |=> !st.pin_oe && !st.pin_out)
    else $error("pin driven in timer mode");

  chk_low_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!st.waitrequest && avs_read && avs_address == stt_pkg::ADDR_CTRL0) |->
      (st.readdata[2:0] == 3'h0))
    else $error("unused control bits read nonzero");

  chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((avs_read || avs_write) && st.waitrequest) |=> !st.waitrequest ##1 st.waitrequest)
    else $error("waitrequest not low for exactly one cycle");

endmodule

// *** sim/stt_pin_model.sv ***
// Purpose: Far-side model of the timer pins: count clock, capture input, output watcher
// Assumes: Pins move just after a system clock edge
// Notes: Four cycles per phase keeps edges slow enough for the pin synchroniser
`timescale 1ns/1ps
module stt_pin_model (
  input wire logic sys_clk, // System clock
  input wire logic pin, // Timer output pin
  input wire logic oe, // Pin output enable
  output logic ext_clk, // External count clock
  output logic cap_in // Capture input
);
  initial begin
    ext_clk = 1'b0;
    cap_in = 1'b0;
  end
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_clk <= 1'b0;
    end
  endtask
  task automatic cap_set(input logic v);
    @(posedge sys_clk);
    cap_in <= v;
    repeat (10) @(posedge sys_clk);
  endtask
  // An undriven pin counts as low
  task automatic count_high(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (pin === 1'b1 && oe === 1'b1) h++;
    end
  endtask
endmodule

// *** sim/tb_stt_timer.sv ***
// Purpose: Self-checking bench for the 16-bit standard timer
// Assumes: Avalon master waits on waitrequest; no fixed answer latency
// Notes: The overflow case runs a full 65536-count period
`timescale 1ns/1ps
module tb_stt_timer;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_clk, cap_in, pin, oe, fa, fp;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  stt_timer u_stt_timer (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_count_clock_pin(ext_clk),
    .capture_input_pin(cap_in), .timer_output_pin(pin), .timer_output_oe(oe),
    .compare_a_flag(fa), .compare_p_flag(fp));
  stt_pin_model u_stt_pin_model (.sys_clk(sys_clk), .pin(pin), .oe(oe), .ext_clk(ext_clk),
    .cap_in(cap_in));
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task automatic rdc(output logic [15:0] c);
    logic [7:0] l, h;
    rd(3'h2, l);
    rd(3'h3, h);
    c = {h, l};
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [15:0] g, input int lo, input int hi);
    compares++;
    if ($isunknown(g) || g < lo || g > hi) begin
      mismatches++;
      $display("BAD %0t got %h outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] q;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), q);
      chk(q, 8'h00);
    end
    wr(3'h0, 8'hff);
    rd(3'h0, q);
    chk(q, 8'hf8);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h55);
    rd(3'h2, q);
    chk(q, 8'h00);
    wr(3'h4, 8'ha5);
    wr(3'h5, 8'h5a);
    wr(3'h6, 8'h3c);
    avs_byteenable <= 4'h0;
    wr(3'h6, 8'hff);
    avs_byteenable <= 4'hf;
    rd(3'h4, q);
    chk(q, 8'ha5);
    rd(3'h5, q);
    chk(q, 8'h5a);
    rd(3'h6, q);
    chk(q, 8'h3c);
  endtask
  task automatic t_hold;
    logic [15:0] c1, c2, c3;
    wr(3'h0, 8'h18);
    cyc(20);
    wr(3'h0, 8'h98);
    rdc(c1);
    cyc(10);
    rdc(c2);
    chk(c2, c1);
    wr(3'h0, 8'h18);
    cyc(10);
    wr(3'h0, 8'h10);
    rdc(c3);
    rng(c3, c1 + 10, c1 + 18);
    cyc(10);
    rdc(c2);
    chk(c2, c3);
    wr(3'h0, 8'h18);
    wr(3'h0, 8'h10);
    rdc(c2);
    rng(c2, 0, 4);
  endtask
  task automatic t_div;
    int dv[6] = '{4, 1, 16, 64, stt_pkg::SUB_DIV, stt_pkg::SUB_DIV};
    logic [15:0] c;
    for (int i = 0; i < 6; i++) begin
      wr(3'h0, {1'b0, 3'(i), 4'h8});
      cyc(8 * dv[i]);
      wr(3'h0, {1'b0, 3'(i), 4'h0});
      rdc(c);
      rng(c, 8, 12);
    end
    for (int i = 6; i < 8; i++) begin
      wr(3'h0, {1'b0, 3'(i), 4'h8});
      u_stt_pin_model.ext_pulses(10);
      cyc(8);
      wr(3'h0, {1'b0, 3'(i), 4'h0});
      rdc(c);
      chk(c, 16'd10);
    end
  endtask
  task automatic t_cmp;
    logic [1:0] pf;
    logic oc, pol, lvl;
    logic [15:0] c;
    wr(3'h4, 8'h20);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h00);
    for (int i = 0; i < 5; i++) begin
      pf = (i < 4) ? 2'(i) : 2'h1;
      oc = (i == 4);
      pol = (i % 2 == 1);
      lvl = (pf == 2'h0) ? oc : (pf == 2'h3) ? !oc : pf[1];
      wr(3'h1, {2'b00, pf, oc, pol, 2'b01});
      wr(3'h7, 8'h03);
      wr(3'h0, 8'h18);
      cyc(3);
      chk(pin, oc ^ pol);
      chk(oe, 1'b1);
      cyc(40);
      wr(3'h0, 8'h10);
      chk(pin, lvl ^ pol);
      chk({fp, fa}, 2'b01);
      rdc(c);
      rng(c, 0, 31);
    end
  endtask
  task automatic t_clear;
    logic [15:0] c;
    wr(3'h1, 8'hc0);
    wr(3'h4, 8'h10);
    wr(3'h6, 8'h01);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
    cyc(300);
    wr(3'h0, 8'h10);
    chk(oe, 1'b0);
    chk({fp, fa}, 2'b11);
    rdc(c);
    rng(c, 40, 60);
    // A beyond the first P boundary, so a P flag would show here
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h20);
    wr(3'h5, 8'h01);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
    cyc(300);
    wr(3'h0, 8'h10);
    chk({fp, fa}, 2'b01);
    rdc(c);
    rng(c, 10, 20);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h00);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
    cyc(65576);
    wr(3'h0, 8'h10);
    chk({fp, fa}, 2'b10);
    rdc(c);
    rng(c, 40, 50);
  endtask
  task automatic t_pwm;
    int h;
    logic [7:0] q;
    wr(3'h1, 8'ha8);
    wr(3'h4, 8'h40);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h18);
    cyc(300);
    u_stt_pin_model.count_high(256, h);
    rng(16'(h), 63, 65);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'haa);
    wr(3'h4, 8'h80);
    wr(3'h0, 8'h18);
    cyc(200);
    u_stt_pin_model.count_high(128, h);
    chk(16'(h), 16'd128);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h88);
    wr(3'h0, 8'h18);
    cyc(4);
    chk(pin, 1'b0);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h98);
    wr(3'h0, 8'h18);
    cyc(4);
    chk(pin, 1'b1);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'hb8);
    wr(3'h4, 8'h30);
    wr(3'h0, 8'h18);
    cyc(3);
    chk(pin, 1'b1);
    cyc(70);
    chk(pin, 1'b0);
    rd(3'h0, q);
    chk(q, 8'h10);
  endtask
  task automatic t_cap;
    for (int p = 0; p < 4; p++) begin
      wr(3'h0, 8'h10);
      wr(3'h1, {2'b01, 2'(p), 4'h0});
      wr(3'h4, 8'h00);
      wr(3'h7, 8'h03);
      wr(3'h0, 8'h18);
      u_stt_pin_model.cap_set(1'b1);
      chk(fa, p == 0 || p == 2);
      chk(oe, 1'b0);
      wr(3'h7, 8'h03);
      u_stt_pin_model.cap_set(1'b0);
      chk(fa, p == 1 || p == 2);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_hold;
    t_div;
    t_cmp;
    t_clear;
    t_pwm;
    t_cap;
    stop_test;
  end
endmodule
